// ---- wrce_pkg.sv ----
// Purpose: constants and types shared by the waveform ram command engine
// Assumes: one 25 MHz clock, asynchronous active-low reset
// Notes:   all field positions and codes of the command words live here
package wrce_pkg;
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned AMP_W = 12;
  localparam int unsigned RAM_DEPTH = 1024;
  localparam logic [15:0] CMD_SYNTH = 16'h0012;
  localparam logic [15:0] CMD_PLAY = 16'h0013;
  localparam logic [15:0] CMD_BURST = 16'h0014;
  localparam logic [1:0] MODE_PLAYBACK = 2'h2;
  localparam logic [1:0] MODE_SYNTH = 2'h3;
  // synthesis word 1 layout
  localparam int unsigned SY_END_HI = 15;
  localparam int unsigned SY_END_LO = 12;
  localparam int unsigned SY_START_HI = 11;
  localparam int unsigned SY_START_LO = 8;
  localparam int unsigned SY_RELATIVE_OFFSET_FLAG = 4;
  localparam int unsigned SY_STOP = 3;
  localparam int unsigned SY_ADVANCE_NEXT_WAVE_FLAG = 2;
  localparam int unsigned SY_ADVANCE_NEXT_SLICE_FLAG = 1;
  localparam int unsigned SY_RPT = 0;
  // playback words layout
  localparam int unsigned PB_RPT = 15;
  localparam int unsigned PB_SA_HI = 14;
  localparam int unsigned PB_SA_LO = 10;
  localparam int unsigned PB_ADDR_HI = 9;
  localparam logic [3:0] WAVE_MAX = 4'he;
  localparam logic [AMP_W-1:0] AMP_ZERO = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 10'h000;
  typedef enum logic [2:0] {
    WRCE_IDLE, WRCE_SY1, WRCE_PB1, WRCE_PB2, WRCE_BA, WRCE_BC, WRCE_BD
  } wrce_cmd_state_t;
endpackage

// ---- wrce_ram.sv ----
// Purpose: 1024 x 16 waveform memory, one write and one read port
// Assumes: read data registered one cycle after the address
// Notes:   shared storage for burst writes and playback fetches
`timescale 1ns/1ps
module wrce_ram (
  // clock
  input  wire logic                          clk_i,
  // write port
  input  wire logic                          wr_en_i,
  input  wire logic [wrce_pkg::ADDR_W-1:0]   wr_addr_i,
  input  wire logic [wrce_pkg::DATA_W-1:0]   wr_data_i,
  // read port
  input  wire logic [wrce_pkg::ADDR_W-1:0]   rd_addr_i,
  output logic      [wrce_pkg::DATA_W-1:0]   rd_data_o
);
  logic [wrce_pkg::DATA_W-1:0] mem [wrce_pkg::RAM_DEPTH];

  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end
endmodule

// ---- wrce_seq.sv ----
// Purpose: wave sequencer for synthesis mode
// Assumes: datapath reports wave_done_i as a pulse
// Notes:   emits the current wave number and an active flag
`timescale 1ns/1ps
module wrce_seq (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  // command
  input  wire logic       load_i,
  input  wire logic [3:0] start_wave_i,
  input  wire logic [3:0] end_wave_i,
  input  wire logic       stop_i,
  input  wire logic       seq_rpt_i,
  input  wire logic       go_i,
  // datapath events
  input  wire logic       wave_done_i,
  // status
  output logic      [3:0] wave_o,
  output logic            active_o
);
  logic [3:0] wave_r;
  logic [3:0] start_r;
  logic [3:0] end_r;
  logic       rpt_r;
  logic       act_r;
  wire        last_wave = (wave_r == end_r);
  wire        wrap = last_wave && rpt_r;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wave_r  <= 4'h0;
      start_r <= 4'h0;
      end_r   <= 4'h0;
      rpt_r   <= 1'b0;
      act_r   <= 1'b0;
    end else if (load_i) begin
      start_r <= start_wave_i;
      end_r   <= end_wave_i;
      rpt_r   <= seq_rpt_i && !stop_i;
      if (!act_r) begin
        wave_r <= start_wave_i;
      end
    end else if (go_i && !act_r) begin
      wave_r <= start_r;
      act_r  <= 1'b1;
    end else if (act_r && wave_done_i) begin
      if (wrap) begin
        wave_r <= start_r;
      end else if (last_wave) begin
        act_r <= 1'b0;
      end else begin
        wave_r <= wave_r + 4'h1;
      end
    end
  end

  assign wave_o   = wave_r;
  assign active_o = act_r;

  a_seq_wrap: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    act_r && wave_done_i && wrap && !load_i |=> wave_r == $past(start_r))
    else $error("sequence did not restart at first wave");
  a_stop_no_wrap: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    load_i && stop_i |=> !rpt_r)
    else $error("sequence repeat kept after stop");
endmodule

// ---- wrce_top.sv ----
// Purpose: command interpreter for waveform ram synthesis, playback and burst write
// Assumes: host words arrive as one-cycle ref_wr_i strobes, synchronous to clk_i
// Notes:   slice shaping datapath lies outside; it reports done events
`timescale 1ns/1ps
module wrce_top (
  // clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          reset_n_i,
  // reference data word from host
  input  wire logic                          ref_wr_i,
  input  wire logic [wrce_pkg::DATA_W-1:0]   ref_data_i,
  // configuration
  input  wire logic [1:0]                    play_mode_i,
  input  wire logic                          out_en_i,
  input  wire logic                          auto_trig_i,
  input  wire logic                          sense_evt_i,
  // playback pacing and synthesis datapath events
  input  wire logic                          sample_tick_i,
  input  wire logic                          slice_done_i,
  input  wire logic                          wave_done_i,
  input  wire logic [wrce_pkg::AMP_W-1:0]    slice_sample_i,
  input  wire logic                          slice_start_i,
  // synthesis outputs
  output logic      [3:0]                    wave_num_o,
  output logic                               synth_active_o,
  output logic                               slice_repeat_ok_o,
  output logic                               wave_repeat_ok_o,
  output logic                               relative_offset_flag_en_o,
  output logic      [wrce_pkg::AMP_W-1:0]    slice_offset_o,
  // playback outputs, with ready shared by synthesis and busy from the command interpreter
  output logic                               ready_o,
  output logic                               play_active_o,
  output logic      [wrce_pkg::AMP_W-1:0]    sample_o,
  output logic                               sample_vld_o,
  output logic                               busy_o
);
  wrce_pkg::wrce_cmd_state_t st_r, st_nxt;

  logic [wrce_pkg::ADDR_W-1:0] pb_end_r;
  logic [wrce_pkg::ADDR_W-1:0] pb_rst_r;
  logic [wrce_pkg::ADDR_W-1:0] pb_addr_r;
  logic [4:0]                  sa_lo_r;
  logic [wrce_pkg::ADDR_W-1:0] w1_end_r;
  logic                        w1_rpt_r;
  logic                        pb_rpt_r;
  logic                        pb_act_r;
  logic                        fetch_r;
  logic [wrce_pkg::ADDR_W-1:0] bw_addr_r;
  logic [wrce_pkg::ADDR_W-1:0] bw_cnt_r;
  logic                        ready_r;
  logic                        stop_r;
  logic                        advance_next_wave_flag_r;
  logic                        advance_next_slice_flag_r;
  logic                        relative_offset_flag_r;
  logic [wrce_pkg::AMP_W-1:0]  last_amp_r;
  logic [wrce_pkg::AMP_W-1:0]  offs_r;
  logic [wrce_pkg::AMP_W-1:0]  sample_r;
  logic                        svld_r;
  logic [wrce_pkg::DATA_W-1:0] ram_q;

  // host words are commands only in the ram modes
  wire cmd_mode = (play_mode_i == wrce_pkg::MODE_PLAYBACK) ||
                  (play_mode_i == wrce_pkg::MODE_SYNTH);
  wire word_in  = ref_wr_i && cmd_mode;

  wire id_synth = word_in && (st_r == wrce_pkg::WRCE_IDLE) &&
                  (ref_data_i == wrce_pkg::CMD_SYNTH);
  wire id_play  = word_in && (st_r == wrce_pkg::WRCE_IDLE) &&
                  (ref_data_i == wrce_pkg::CMD_PLAY);
  wire id_burst = word_in && (st_r == wrce_pkg::WRCE_IDLE) &&
                  (ref_data_i == wrce_pkg::CMD_BURST);

  wire synth_done = word_in && (st_r == wrce_pkg::WRCE_SY1);
  wire play_done  = word_in && (st_r == wrce_pkg::WRCE_PB2);
  wire bw_data    = word_in && (st_r == wrce_pkg::WRCE_BD);
  wire bw_last    = bw_data && (bw_cnt_r == wrce_pkg::ADDR_W'(1));
  wire bc_zero    = ref_data_i[wrce_pkg::PB_ADDR_HI:0] == wrce_pkg::ADDR_ZERO;

  // split start address reassembled from word 1 low half and word 2 high half
  wire [wrce_pkg::ADDR_W-1:0] new_start =
    {ref_data_i[wrce_pkg::PB_SA_HI:wrce_pkg::PB_SA_LO], sa_lo_r};
  // a running repeating playback keeps its current address
  wire keep_addr = pb_act_r && pb_rpt_r;
  wire at_end    = pb_addr_r == pb_end_r;
  wire synth_go  = ready_r && (out_en_i || (auto_trig_i && sense_evt_i));
  wire synth_trg = synth_go && (play_mode_i == wrce_pkg::MODE_SYNTH) && !synth_active_o;

  always_comb begin
    st_nxt = st_r;
    if (word_in) begin
      case (st_r)
        wrce_pkg::WRCE_IDLE: begin
          if (id_synth) begin
            st_nxt = wrce_pkg::WRCE_SY1;
          end else if (id_play) begin
            st_nxt = wrce_pkg::WRCE_PB1;
          end else if (id_burst) begin
            st_nxt = wrce_pkg::WRCE_BA;
          end
        end
        wrce_pkg::WRCE_SY1: st_nxt = wrce_pkg::WRCE_IDLE;
        wrce_pkg::WRCE_PB1: st_nxt = wrce_pkg::WRCE_PB2;
        wrce_pkg::WRCE_PB2: st_nxt = wrce_pkg::WRCE_IDLE;
        wrce_pkg::WRCE_BA:  st_nxt = wrce_pkg::WRCE_BC;
        wrce_pkg::WRCE_BC:  st_nxt = bc_zero ? wrce_pkg::WRCE_IDLE : wrce_pkg::WRCE_BD;
        wrce_pkg::WRCE_BD:  st_nxt = bw_last ? wrce_pkg::WRCE_IDLE : wrce_pkg::WRCE_BD;
        default:            st_nxt = wrce_pkg::WRCE_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r <= wrce_pkg::WRCE_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // burst write address and count
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bw_addr_r <= wrce_pkg::ADDR_ZERO;
      bw_cnt_r  <= wrce_pkg::ADDR_ZERO;
    end else if (word_in && st_r == wrce_pkg::WRCE_BA) begin
      bw_addr_r <= ref_data_i[wrce_pkg::PB_ADDR_HI:0];
    end else if (word_in && st_r == wrce_pkg::WRCE_BC) begin
      bw_cnt_r <= ref_data_i[wrce_pkg::PB_ADDR_HI:0];
    end else if (bw_data) begin
      bw_addr_r <= bw_addr_r + wrce_pkg::ADDR_W'(1);
      bw_cnt_r  <= bw_cnt_r - wrce_pkg::ADDR_W'(1);
    end
  end

  // playback command words and fetch pointer
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sa_lo_r   <= 5'h00;
      w1_end_r  <= wrce_pkg::ADDR_ZERO;
      w1_rpt_r  <= 1'b0;
      pb_end_r  <= wrce_pkg::ADDR_ZERO;
      pb_rst_r  <= wrce_pkg::ADDR_ZERO;
      pb_addr_r <= wrce_pkg::ADDR_ZERO;
      pb_rpt_r  <= 1'b0;
      pb_act_r  <= 1'b0;
      fetch_r   <= 1'b0;
    end else begin
      fetch_r <= 1'b0;
      if (word_in && st_r == wrce_pkg::WRCE_PB1) begin
        w1_rpt_r <= ref_data_i[wrce_pkg::PB_RPT];
        sa_lo_r  <= ref_data_i[wrce_pkg::PB_SA_HI:wrce_pkg::PB_SA_LO];
        w1_end_r <= ref_data_i[wrce_pkg::PB_ADDR_HI:0];
      end
      if (play_done) begin
        pb_end_r <= w1_end_r;
        pb_rpt_r <= w1_rpt_r;
        if (w1_rpt_r) begin
          pb_rst_r <= ref_data_i[wrce_pkg::PB_ADDR_HI:0];
        end
        if (!keep_addr) begin
          pb_addr_r <= new_start;
          pb_act_r  <= 1'b0;
        end
      end else if (pb_act_r && sample_tick_i) begin
        fetch_r <= 1'b1;
        if (at_end && pb_rpt_r) begin
          pb_addr_r <= pb_rst_r;
        end else if (at_end) begin
          pb_act_r <= 1'b0;
        end else begin
          pb_addr_r <= pb_addr_r + wrce_pkg::ADDR_W'(1);
        end
      end else if (ready_r && out_en_i && play_mode_i == wrce_pkg::MODE_PLAYBACK) begin
        pb_act_r <= 1'b1;
      end
    end
  end

  // readiness and synthesis flags
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ready_r  <= 1'b0;
      stop_r   <= 1'b0;
      advance_next_wave_flag_r  <= 1'b0;
      advance_next_slice_flag_r  <= 1'b0;
      relative_offset_flag_r <= 1'b0;
    end else begin
      if (synth_done) begin
        ready_r <= 1'b1;
      end else if (play_done) begin
        ready_r <= 1'b1;
      end else if (synth_trg || synth_active_o || pb_act_r) begin
        // consumed while running, so a finished or stopped run never restarts itself
        ready_r <= 1'b0;
      end
      if (synth_done) begin
        stop_r   <= ref_data_i[wrce_pkg::SY_STOP];
        advance_next_wave_flag_r  <= ref_data_i[wrce_pkg::SY_ADVANCE_NEXT_WAVE_FLAG];
        advance_next_slice_flag_r  <= ref_data_i[wrce_pkg::SY_ADVANCE_NEXT_SLICE_FLAG];
        relative_offset_flag_r <= ref_data_i[wrce_pkg::SY_RELATIVE_OFFSET_FLAG];
      end else begin
        // advance requests are one-shot: consumed when their boundary passes
        if (wave_done_i) begin
          advance_next_wave_flag_r <= 1'b0;
        end
        if (slice_done_i) begin
          advance_next_slice_flag_r <= 1'b0;
        end
      end
    end
  end

  // relative offset: first slice cancels its own start, later ones carry the last sample
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      last_amp_r <= wrce_pkg::AMP_ZERO;
      offs_r     <= wrce_pkg::AMP_ZERO;
    end else if (synth_trg) begin
      last_amp_r <= wrce_pkg::AMP_ZERO;
    end else if (relative_offset_flag_r && slice_start_i) begin
      offs_r <= last_amp_r - slice_sample_i;
    end else if (relative_offset_flag_r && sample_tick_i) begin
      last_amp_r <= slice_sample_i + offs_r;
    end
  end

  // sample output registered from ram
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sample_r <= wrce_pkg::AMP_ZERO;
      svld_r   <= 1'b0;
    end else begin
      svld_r <= fetch_r;
      if (fetch_r) begin
        sample_r <= ram_q[wrce_pkg::AMP_W-1:0];
      end
    end
  end

  wrce_ram u_ram (
    .clk_i     (clk_i),
    .wr_en_i   (bw_data),
    .wr_addr_i (bw_addr_r),
    .wr_data_i (ref_data_i),
    .rd_addr_i (pb_addr_r),
    .rd_data_o (ram_q)
  );

  wrce_seq u_seq (
    .clk_i        (clk_i),
    .reset_n_i    (reset_n_i),
    .load_i       (synth_done),
    .start_wave_i (ref_data_i[wrce_pkg::SY_START_HI:wrce_pkg::SY_START_LO]),
    .end_wave_i   (ref_data_i[wrce_pkg::SY_END_HI:wrce_pkg::SY_END_LO]),
    .stop_i       (ref_data_i[wrce_pkg::SY_STOP]),
    .seq_rpt_i    (ref_data_i[wrce_pkg::SY_RPT]),
    .go_i         (synth_trg),
    .wave_done_i  (wave_done_i),
    .wave_o       (wave_num_o),
    .active_o     (synth_active_o)
  );

  // stop forbids any repetition; advance flags end continuous play
  assign slice_repeat_ok_o = !stop_r && !advance_next_slice_flag_r;
  assign wave_repeat_ok_o  = !stop_r && !advance_next_wave_flag_r;
  assign relative_offset_flag_en_o       = relative_offset_flag_r;
  assign slice_offset_o    = offs_r;
  assign ready_o           = ready_r;
  assign play_active_o     = pb_act_r;
  assign sample_o          = sample_r;
  assign sample_vld_o      = svld_r;
  assign busy_o            = st_r != wrce_pkg::WRCE_IDLE;

  a_burst_addr_inc: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    bw_data |=> bw_addr_r == $past(bw_addr_r) + wrce_pkg::ADDR_W'(1))
    else $error("burst address did not increment");
  a_play_ready: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    play_done |=> ready_r)
    else $error("playback command did not mark ready");
  a_synth_ready: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    synth_done |=> ready_r)
    else $error("synthesis command did not mark ready");
  a_pb_wrap: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    pb_act_r && sample_tick_i && at_end && pb_rpt_r && !play_done
    |=> pb_addr_r == $past(pb_rst_r))
    else $error("repeat did not wrap to repeat start");
  a_pb_end: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    pb_act_r && sample_tick_i && at_end && !pb_rpt_r && !play_done |=> !pb_act_r)
    else $error("playback did not end at end address");
  a_keep_start: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    play_done && keep_addr && !sample_tick_i |=> $stable(pb_addr_r))
    else $error("start address taken during repeat");
  a_rst_ignored: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    play_done && !w1_rpt_r |=> $stable(pb_rst_r))
    else $error("repeat start taken without repeat");
  a_sample_bits: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    fetch_r |=> sample_o == $past(ram_q[wrce_pkg::AMP_W-1:0]) && sample_vld_o)
    else $error("sample not taken from low bits");
  a_stop_norpt: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    stop_r |-> !slice_repeat_ok_o && !wave_repeat_ok_o)
    else $error("repeat allowed after stop");
  a_idle_after: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    synth_done || play_done |=> st_r == wrce_pkg::WRCE_IDLE)
    else $error("interpreter not back to identifier");
  a_ready_spent: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (synth_active_o || pb_act_r) && !synth_done && !play_done |=> !ready_r)
    else $error("ready kept while already playing");
endmodule

// ---- wrce_host_model.sv ----
// Purpose: host model writing command words to the reference register
// Assumes: words launch just after a falling edge, one per clock cycle
// Notes:   a released data bus shows the inverse of the last word
`timescale 1ns/1ps
module wrce_host_model (
  // clock
  input  wire logic        clk_i,
  // reference word strobe
  output logic             ref_wr_o,
  output logic      [15:0] ref_data_o
);
  initial begin
    ref_wr_o   = 1'b0;
    ref_data_o = 16'h0000;
  end
  // callers keep bursts in range, in playback mode, ram loaded before playback
  task automatic send(input logic [15:0] w[$]);
    foreach (w[i]) begin
      @(negedge clk_i);
      ref_wr_o   = 1'b1;
      ref_data_o = w[i];
    end
    @(negedge clk_i);
    ref_wr_o   = 1'b0;
    ref_data_o = ~ref_data_o; // no pull on the bus, never leave the old word
  endtask
endmodule

// ---- tb_waveform_ram_command_engine.sv ----
// Purpose: self-checking bench for the waveform ram command engine
// Assumes: 25 MHz clock, inputs driven at the falling edge
// Notes:   datapath events are plain pulses made by the bench
`timescale 1ns/1ps
module tb_waveform_ram_command_engine;
  logic        clk_i;
  logic        reset_n_i;
  logic [1:0]  play_mode;
  logic        out_en;
  logic        auto_trig;
  logic [4:0]  ev;
  logic [11:0] slice_sample;
  logic        ref_wr;
  logic [15:0] ref_data;
  logic [3:0]  wave_num_o;
  logic        synth_active_o;
  logic        slice_ok;
  logic        wave_ok;
  logic        relative_offset_flag_en_o;
  logic [11:0] slice_offset_o;
  logic        ready_o;
  logic        play_active_o;
  logic [11:0] sample_o;
  logic        sample_vld_o;
  logic        busy_o;
  int          errors;
  int          checks_done;

  wrce_host_model host (.clk_i(clk_i), .ref_wr_o(ref_wr), .ref_data_o(ref_data));

  wrce_top dut_u (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .ref_wr_i(ref_wr), .ref_data_i(ref_data),
    .play_mode_i(play_mode), .out_en_i(out_en), .auto_trig_i(auto_trig),
    .sense_evt_i(ev[3]), .sample_tick_i(ev[4]), .slice_done_i(ev[0]),
    .wave_done_i(ev[1]), .slice_sample_i(slice_sample), .slice_start_i(ev[2]),
    .wave_num_o(wave_num_o), .synth_active_o(synth_active_o),
    .slice_repeat_ok_o(slice_ok), .wave_repeat_ok_o(wave_ok),
    .relative_offset_flag_en_o(relative_offset_flag_en_o), .slice_offset_o(slice_offset_o), .ready_o(ready_o),
    .play_active_o(play_active_o), .sample_o(sample_o), .sample_vld_o(sample_vld_o),
    .busy_o(busy_o)
  );

  always #20 clk_i = ~clk_i;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // one-cycle pulse on the selected datapath events
  task automatic pulse(input logic [4:0] m);
    @(negedge clk_i);
    ev = m;
    @(negedge clk_i);
    ev = 5'h00;
  endtask

  // pace one fetch and compare the amplitude that comes back
  task automatic fetch(input logic [11:0] exp);
    pulse(5'h10);
    for (int i = 0; i < 6 && sample_vld_o !== 1'b1; i++) @(negedge clk_i);
    chk(16'(sample_vld_o), 16'h0001);
    chk(16'(sample_o), 16'(exp));
  endtask

  task automatic wait_play(input logic lvl);
    for (int i = 0; i < 8 && play_active_o !== lvl; i++) @(negedge clk_i);
    chk(16'(play_active_o), 16'(lvl));
  endtask

  task automatic wait_synth(input logic lvl);
    for (int i = 0; i < 8 && synth_active_o !== lvl; i++) @(negedge clk_i);
    chk(16'(synth_active_o), 16'(lvl));
  endtask

  task automatic t_refuse;
    play_mode = 2'h1;
    host.send('{16'h0014});
    chk(16'(busy_o), 16'h0000);
    play_mode = 2'h2;
    host.send('{16'h0014});
    chk(16'(busy_o), 16'h0001);
    host.send('{16'h0000, 16'h0000});
    chk(16'(busy_o), 16'h0000);
    host.send('{16'h0099});
    chk(16'(busy_o), 16'h0000);
  endtask

  task automatic t_burst_play;
    host.send('{16'h0014, 16'h03fd, 16'h0002, 16'ha123, 16'h5456});
    chk(16'(busy_o), 16'h0000);
    host.send('{16'h0013, 16'h77fe, 16'h7d55});
    for (int i = 0; i < 4 && ready_o !== 1'b1; i++) @(negedge clk_i);
    chk(16'(ready_o), 16'h0001);
    chk(16'(play_active_o), 16'h0000);
    out_en = 1'b1;
    wait_play(1'b1);
    fetch(12'h123);
    fetch(12'h456);
    wait_play(1'b0);
  endtask

  task automatic t_repeat;
    host.send('{16'h0013, 16'hf7fe, 16'h7ffe});
    wait_play(1'b1);
    fetch(12'h123);
    fetch(12'h456);
    fetch(12'h456);
    host.send('{16'h0013, 16'h03fe, 16'h0000});
    fetch(12'h456);
    wait_play(1'b0);
  endtask

  task automatic t_synth;
    play_mode = 2'h3;
    out_en = 1'b0;
    host.send('{16'h0012, 16'h2101});
    for (int i = 0; i < 4 && ready_o !== 1'b1; i++) @(negedge clk_i);
    chk(16'(ready_o), 16'h0001);
    chk(16'(synth_active_o), 16'h0000);
    out_en = 1'b1;
    wait_synth(1'b1);
    chk(16'(wave_num_o), 16'h0001);
    chk(16'(wave_ok), 16'h0001);
    pulse(5'h02);
    chk(16'(wave_num_o), 16'h0002);
    pulse(5'h02);
    chk(16'(wave_num_o), 16'h0001);
    host.send('{16'h0012, 16'h2108});
    @(negedge clk_i);
    chk(16'(wave_ok), 16'h0000);
    chk(16'(slice_ok), 16'h0000);
    pulse(5'h02);
    pulse(5'h02);
    wait_synth(1'b0);
    host.send('{16'h0012, 16'h3304});
    wait_synth(1'b1);
    chk(16'(wave_num_o), 16'h0003);
    chk(16'(wave_ok), 16'h0000);
    chk(16'(slice_ok), 16'h0001);
    host.send('{16'h0012, 16'h3302});
    @(negedge clk_i);
    chk(16'(slice_ok), 16'h0000);
    pulse(5'h01);
    chk(16'(slice_ok), 16'h0001);
    pulse(5'h02);
    wait_synth(1'b0);
  endtask

  task automatic t_auto_relative_offset_flag;
    out_en = 1'b0;
    auto_trig = 1'b1;
    host.send('{16'h0012, 16'h5510});
    for (int i = 0; i < 4 && ready_o !== 1'b1; i++) @(negedge clk_i);
    chk(16'(synth_active_o), 16'h0000);
    pulse(5'h08);
    wait_synth(1'b1);
    chk(16'(relative_offset_flag_en_o), 16'h0001);
    chk(16'(slice_offset_o), 16'h0000);
    slice_sample = 12'h123;
    pulse(5'h01);
    pulse(5'h04);
    @(negedge clk_i);
    chk(16'(slice_offset_o), 16'h0edd);
    // last output = 0x200 - 0x123; a zero-based next slice carries it as offset
    slice_sample = 12'h200;
    pulse(5'h10);
    slice_sample = 12'h000;
    pulse(5'h04);
    @(negedge clk_i);
    chk(16'(slice_offset_o), 16'h00dd);
    pulse(5'h02);
    wait_synth(1'b0);
    auto_trig = 1'b0;
  endtask

  initial begin
    // a hang must not outlive 4000 clock cycles, far beyond the planned run
    #(40 * 4000);
    errors++;
    wrap_up();
  end

  initial begin
    clk_i = 1'b0;
    reset_n_i = 1'b0;
    play_mode = 2'h2;
    out_en = 1'b0;
    auto_trig = 1'b0;
    ev = 5'h00;
    slice_sample = 12'h000;
    errors = 0;
    checks_done = 0;
    repeat (3) @(negedge clk_i);
    reset_n_i = 1'b1;
    t_refuse();
    t_burst_play();
    t_repeat();
    t_synth();
    t_auto_relative_offset_flag();
    wrap_up();
  end
endmodule
